// >>> rtl/lite_timer_pkg.sv
// Package for the lite timer: register indices, field positions, reset values, timing.
// Assumes a 125 MHz core clock and 32-bit APB with one register per word.
package lite_timer_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_TB2_CSR = 8'h08;
   localparam logic [7:0] IDX_TB2_RELOAD = 8'h09;
   localparam logic [7:0] IDX_TB2_COUNT = 8'h0a;
   localparam logic [7:0] IDX_TB1_CSR = 8'h0b;
   localparam logic [7:0] IDX_CAPTURE = 8'h0c;
   // Extra registers for the interrupt block and power mode
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h11;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h12;
   localparam logic [7:0] IDX_POWER_MODE = 8'h13;
   // Field positions
   localparam int TB2_FLAG_BIT = 0;
   localparam int TB2_IE_BIT = 1;
   localparam int TB1_FLAG_BIT = 3;
   localparam int TB1_IE_BIT = 4;
   localparam int PERIOD_SEL_BIT = 5;
   localparam int CAP_FLAG_BIT = 6;
   localparam int CAP_IE_BIT = 7;
   // Status bit positions of the sticky event register
   localparam int EV_TB1 = 0;
   localparam int EV_TB2 = 1;
   localparam int EV_CAP = 2;
   // Reset values and counter limits
   localparam logic [7:0] RST_RELOAD = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_CAPTURE = 8'h00;
   localparam logic [7:0] TB1_WRAP = 8'hf9;
   localparam logic [7:0] TB2_TOP = 8'hff;
   // Timing: source clock is the core clock, counters tick at source / 32
   localparam int CORE_CLK_MHZ = 125;
   localparam int SRC_DIV = 32;
   // Power modes
   typedef enum logic [2:0] {
      PM_RUN,
      PM_SLOW,
      PM_WAIT,
      PM_ACTIVE_HALT,
      PM_HALT
   } power_mode_t;
endpackage : lite_timer_pkg

// >>> rtl/lite_tick_div.sv
// Divider producing a one-cycle tick enable from the core clock.
// Assumes a synchronous active-high reset; run stalls the divider.
module lite_tick_div #(
   parameter int DIV = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control
   input wire logic run,
   output logic tick
);
   localparam int W = $clog2(DIV);

   // Refuse a divider that cannot make a one-cycle tick
   if (DIV < 2) begin : g_div_check
      $error("lite_tick_div: DIV must be at least 2");
   end

   logic [W-1:0] cnt_q;

   // Count source periods; hold while stopped so the phase resumes cleanly
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (run) begin
         tick <= (cnt_q == W'(DIV - 1));
         cnt_q <= (cnt_q == W'(DIV - 1)) ? '0 : cnt_q + 1'b1;
      end else begin
         tick <= 1'b0;
      end
   end
endmodule : lite_tick_div

// >>> rtl/lite_timer.sv
// Lite timer: fixed timebase 1, autoreload timebase 2, 8-bit input capture.
// Assumes an APB master on core_clk; capture pin is asynchronous.
//
// Contract
// [R1] Counter 2 is an 8-bit upcounter, readable but not writable.
// [R2] After reset counter 2 starts from reload value, ticking at source/32.
// [R3] Counter 2 at FFh overflows: flag event and reload, not wrap.
// [R4] Reload writable anytime; new value used only at next overflow.
// [R5] Overflow sets timebase2 flag bit 0; bit 1 enables its interrupt.
// [R6] Reading the timebase2 status register clears its flag; writes ignored.
// [R7] Software keeps bits 7:2 of timebase2 status register zero.
// [R8] Halt stops counting; slow, wait and active-halt keep running.
// [R9] Three separate interrupt request lines, one per event.
// [R10] A request stands only while flag and enable both set.
// [R11] Period select bit 5: 8000 or 16000 source periods for timebase 1.
// [R12] Timebase1 overflow sets bit 3; bit 4 enables; read clears flag.
// [R13] Capture sets bit 6; bit 7 enables; cleared by reading capture.
// [R14] Software reads the capture register once after each reset.
// [R15] Pin edge while capture flag clear latches counter; reset clears it.
// [R16] All events wake from wait; only timebase1 from active-halt.
// [R17] Counter 1 is hidden, ticks at source/32, overflows F9h to 00h.
// [R18] Captured value is taken from counter 1.
module lite_timer
   import lite_timer_pkg::*;
#(
   parameter int TICK_DIV = SRC_DIV
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Capture pin
   input wire logic capture_input_pin,
   // Interrupt requests
   output logic tb1_irq,
   output logic tb2_irq,
   output logic cap_irq,
   output logic irq,
   // Wake-up request to the power controller
   output logic wake_req
);
   // Refuse a divider that cannot make a one-cycle tick
   if (TICK_DIV < 2) begin : g_div_check
      $error("lite_timer: TICK_DIV must be at least 2");
   end

   // Register state
   logic [7:0] timebase2_count_q;
   logic [7:0] timebase2_reload_q;
   logic [7:0] timebase1_count_q;
   logic period_half_q;
   logic [7:0] capture_value_q;
   logic timebase2_flag_q;
   logic timebase2_irq_enable_q;
   logic timebase1_flag_q;
   logic timebase1_irq_enable_q;
   logic period_select_q;
   logic capture_flag_q;
   logic capture_irq_enable_q;
   logic [2:0] ev_status_q;
   logic [2:0] ev_enable_q;
   power_mode_t pmode_q;
   logic [2:0] pin_sync_q;

   // APB decode: register index is the word address
   // Only byte lane 0 carries register bits; a write without it is dropped
   logic [7:0] idx;
   logic acc;
   logic wr;
   logic rd;
   logic mapped;
   assign idx = paddr[9:2];
   assign acc = psel && penable;
   assign wr = acc && pwrite && pstrb[0];
   assign rd = acc && !pwrite;

   // Unmapped indices and misaligned addresses get pslverr
   always_comb begin
      case (idx)
         IDX_TB2_CSR, IDX_TB2_RELOAD, IDX_TB2_COUNT, IDX_TB1_CSR, IDX_CAPTURE,
         IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR, IDX_POWER_MODE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00) begin
         mapped = 1'b0;
      end
   end

   // Flags as they stood when read data was sampled in the setup cycle.
   // A read clears only what it reported, so an event landing on the setup
   // edge stays visible to the next read instead of being lost.
   logic [2:0] flag_seen_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         flag_seen_q <= 3'b000;
      end else if (psel && !penable) begin
         flag_seen_q <= {capture_flag_q, timebase2_flag_q, timebase1_flag_q};
      end
   end

   // Read side effects, taken at the single access edge
   logic rd_tb2_csr;
   logic rd_tb1_csr;
   logic rd_capture;
   assign rd_tb2_csr = rd && mapped && idx == IDX_TB2_CSR && flag_seen_q[EV_TB2]; // R6
   assign rd_tb1_csr = rd && mapped && idx == IDX_TB1_CSR && flag_seen_q[EV_TB1]; // R12
   assign rd_capture = rd && mapped && idx == IDX_CAPTURE && flag_seen_q[EV_CAP]; // R13

   // Halt freezes the counters, other low-power modes do not
   logic run;
   assign run = (pmode_q != PM_HALT); // R8

   logic tick;
   lite_tick_div #(
      .DIV(TICK_DIV)
   ) u_div (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(run),
      .tick(tick)
   );

   // Counter 1: hidden, F9h back to 00h; every second wrap counts when period doubled
   // After the select bit is set, the first event may come after one or two wraps,
   // since the half-period phase is not realigned by the write
   logic tb1_wrap;
   logic tb1_event;
   assign tb1_wrap = tick && timebase1_count_q == TB1_WRAP; // R17
   assign tb1_event = tb1_wrap && (!period_select_q || period_half_q); // R11

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timebase1_count_q <= RST_COUNT;
         period_half_q <= 1'b0;
      end else if (tick) begin
         timebase1_count_q <= tb1_wrap ? 8'h00 : timebase1_count_q + 8'h01; // R17
         if (tb1_wrap) begin
            period_half_q <= period_select_q ? !period_half_q : 1'b0; // R11
         end
      end
   end

   // Counter 2 starts at the reload value after reset, which is the reset reload
   // It never wraps to zero: every overflow reloads
   logic tb2_event;
   assign tb2_event = tick && timebase2_count_q == TB2_TOP; // R3

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timebase2_count_q <= RST_RELOAD; // R2
      end else if (tick) begin
         timebase2_count_q <= tb2_event ? timebase2_reload_q : timebase2_count_q + 8'h01; // R3 R4
      end
   end

   // Reload register: written anytime, only consumed at overflow
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timebase2_reload_q <= RST_RELOAD;
      end else if (wr && mapped && idx == IDX_TB2_RELOAD) begin
         timebase2_reload_q <= pwdata[7:0]; // R4
      end
   end

   // Capture pin synchroniser; edge detect reads only stages 2 and 3
   // Both edges capture; a pin pulse shorter than one clock may be missed
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_sync_q <= 3'b000;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], capture_input_pin};
      end
   end

   logic cap_event;
   assign cap_event = (pin_sync_q[2] ^ pin_sync_q[1]) && !capture_flag_q; // R15

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         capture_value_q <= RST_CAPTURE; // R15
      end else if (cap_event) begin
         capture_value_q <= timebase1_count_q; // R18
      end
   end

   // Flags: a set in the same cycle as a read-clear wins
   // A read clear acts only on a flag that the same read reported
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timebase2_flag_q <= 1'b0;
         timebase1_flag_q <= 1'b0;
         capture_flag_q <= 1'b0; // Undefined by design, cleared here for determinism
      end else begin
         if (tb2_event) begin
            timebase2_flag_q <= 1'b1; // R5
         end else if (rd_tb2_csr) begin
            timebase2_flag_q <= 1'b0; // R6
         end
         if (tb1_event) begin
            timebase1_flag_q <= 1'b1; // R12
         end else if (rd_tb1_csr) begin
            timebase1_flag_q <= 1'b0; // R12
         end
         if (cap_event) begin
            capture_flag_q <= 1'b1; // R13
         end else if (rd_capture) begin
            capture_flag_q <= 1'b0; // R13
         end
      end
   end

   // Control bits; flag positions ignore writes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timebase2_irq_enable_q <= 1'b0;
         timebase1_irq_enable_q <= 1'b0;
         period_select_q <= 1'b0;
         capture_irq_enable_q <= 1'b0;
      end else if (wr && mapped) begin
         if (idx == IDX_TB2_CSR) begin
            timebase2_irq_enable_q <= pwdata[TB2_IE_BIT]; // R5
         end
         if (idx == IDX_TB1_CSR) begin
            capture_irq_enable_q <= pwdata[CAP_IE_BIT]; // R13
            period_select_q <= pwdata[PERIOD_SEL_BIT]; // R11
            timebase1_irq_enable_q <= pwdata[TB1_IE_BIT]; // R12
         end
      end
   end

   // Power mode register
   // Unknown codes fall back to run rather than freezing the timer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pmode_q <= PM_RUN;
      end else if (wr && mapped && idx == IDX_POWER_MODE) begin
         case (pwdata[2:0])
            3'h1: pmode_q <= PM_SLOW;
            3'h2: pmode_q <= PM_WAIT;
            3'h3: pmode_q <= PM_ACTIVE_HALT;
            3'h4: pmode_q <= PM_HALT;
            default: pmode_q <= PM_RUN;
         endcase
      end
   end

   // Sticky event status: write-one-to-clear via clear register, set wins
   // Kept apart from the per-event flags, so reading the timer registers
   // leaves this bank untouched
   logic [2:0] ev_set;
   assign ev_set = {cap_event, tb2_event, tb1_event};

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ev_status_q <= 3'b000;
         ev_enable_q <= 3'b000;
      end else begin
         if (wr && mapped && idx == IDX_IRQ_CLEAR) begin
            ev_status_q <= (ev_status_q & ~pwdata[2:0]) | ev_set;
         end else begin
            ev_status_q <= ev_status_q | ev_set;
         end
         if (wr && mapped && idx == IDX_IRQ_ENABLE) begin
            ev_enable_q <= pwdata[2:0];
         end
      end
   end

   // Request lines: one per event, each flag gated by its enable
   // The processor-side global mask sits beyond these lines
   logic tb1_req;
   logic tb2_req;
   logic cap_req;
   assign tb1_req = timebase1_flag_q && timebase1_irq_enable_q; // R10
   assign tb2_req = timebase2_flag_q && timebase2_irq_enable_q; // R10
   assign cap_req = capture_flag_q && capture_irq_enable_q; // R10

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tb1_irq <= 1'b0;
         tb2_irq <= 1'b0;
         cap_irq <= 1'b0;
         irq <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         tb1_irq <= tb1_req; // R9
         tb2_irq <= tb2_req; // R9
         cap_irq <= cap_req; // R9
         irq <= |(ev_status_q & ev_enable_q);
         case (pmode_q)
            PM_WAIT: wake_req <= tb1_req || tb2_req || cap_req; // R16
            PM_ACTIVE_HALT: wake_req <= tb1_req; // R16
            default: wake_req <= 1'b0; // R16
         endcase
      end
   end

   // Read mux
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      case (idx)
         IDX_TB2_CSR: rd_byte = {6'h00, timebase2_irq_enable_q, timebase2_flag_q};
         IDX_TB2_RELOAD: rd_byte = timebase2_reload_q;
         IDX_TB2_COUNT: rd_byte = timebase2_count_q; // R1
         IDX_TB1_CSR: rd_byte = {capture_irq_enable_q, capture_flag_q, period_select_q,
                                 timebase1_irq_enable_q, timebase1_flag_q, 3'b000};
         IDX_CAPTURE: rd_byte = capture_value_q;
         IDX_IRQ_STATUS: rd_byte = {5'h00, ev_status_q};
         IDX_IRQ_ENABLE: rd_byte = {5'h00, ev_enable_q};
         IDX_POWER_MODE: rd_byte = {5'h00, pmode_q};
         default: rd_byte = 8'h00;
      endcase
   end

   // APB answer in the first access cycle, zero wait states
   // Read data is sampled in the setup cycle, so the read mux works on the
   // address one cycle before the access edge that applies side effects
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= (psel && !penable && !pwrite && mapped) ? {24'h000000, rd_byte}
                                                             : 32'h0000_0000;
      end
   end
endmodule : lite_timer

// >>> tb/lite_timer_sva.sv
// Checker for lite_timer: APB answer timing and read data against irq lines.
// Assumes one core clock domain; bound to every lite_timer instance.
module lite_timer_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Interrupt requests
   input wire logic tb1_irq,
   input wire logic tb2_irq,
   input wire logic cap_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Bus phases; reads are judged in the access cycle
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_acc;
      psel && penable && pready;
   endsequence
   sequence s_rd(logic [11:0] ad);
      s_acc ##0 (!pwrite && !pslverr && paddr == ad);
   endsequence
   property p_ready;
      s_setup |=> s_acc;
   endproperty
   property p_one;
      pready |=> !pready;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_align;
      s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr;
   endproperty
   property p_hi;
      pready && !pwrite |-> prdata[31:8] == 24'h0;
   endproperty
   property p_rsv;
      s_rd(12'h020) |-> prdata[7:2] == 6'h0;
   endproperty
   // Flag and enable seen on the bus must agree with the request line
   property p_tb2;
      s_rd(12'h020) |-> tb2_irq == (prdata[0] && prdata[1]);
   endproperty
   property p_tb1;
      s_rd(12'h02c) |-> tb1_irq == (prdata[3] && prdata[4]);
   endproperty
   property p_cap;
      s_rd(12'h02c) |-> cap_irq == (prdata[6] && prdata[7]);
   endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   a_one: assert property (p_one) else $error("ready held too long");
   a_err: assert property (p_err) else $error("error without ready");
   a_align: assert property (p_align) else $error("misaligned not refused");
   a_hi: assert property (p_hi) else $error("upper read bits set");
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   a_tb2: assert property (p_tb2) else $error("tb2 request mismatch");
   a_tb1: assert property (p_tb1) else $error("tb1 request mismatch");
   a_cap: assert property (p_cap) else $error("capture request mismatch");
endmodule : lite_timer_sva

bind lite_timer lite_timer_sva u_lite_timer_sva (.core_clk, .sys_rst, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .tb1_irq, .tb2_irq, .cap_irq);

// >>> tb/tb.sv
// Bench for lite_timer: registers, counters, flags, interrupts and capture over APB.
// Assumes TICK_DIV of 2, so one counter tick is two core clocks.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, sys_rst, psel, penable, pwrite, capture_input_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, a;
   logic [3:0] pstrb;
   logic pready, pslverr, tb1_irq, tb2_irq, cap_irq, irq, wake_req, serr;
   int err_count, check_count, cyc;

   lite_timer #(.TICK_DIV(2)) u_lite_timer (.core_clk, .sys_rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .capture_input_pin,
      .tb1_irq, .tb2_irq, .cap_irq, .irq, .wake_req);

   // Clock and a cycle count for period checks
   initial begin
      core_clk = 1'h0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;

   task automatic complete_run();
      $display("mismatches %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic chb(input logic s, input logic e);
      chk({31'h0, s}, {31'h0, e});
   endtask : chb

   task automatic tmo();
      err_count++;
      $display("CHECK FAILED %0t: wait ran out", $time);
      complete_run();
   endtask : tmo

   // One transfer; entered after an edge, leaves one edge after release
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) tmo();
      rv = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask : apb

   // Reading clears the flag, so each hit after the first marks a fresh event
   task automatic poll(input logic [11:0] ad, input int b);
      int n;
      n = 0;
      do begin
         apb(1'h0, ad, 32'h0);
         n++;
      end while (rv[b] !== 1'h1 && n < 800);
      if (n >= 800) tmo();
   endtask : poll

   task automatic wait_hi(input logic sel);
      int n;
      for (n = 0; n < 1200 && (sel ? tb2_irq : irq) !== 1'h1; n++) @(posedge core_clk);
      if (n >= 1200) tmo();
   endtask : wait_hi

   task automatic t_reset();
      apb(1'h0, 12'h030, 32'h0);
      chk(rv, 32'h0);
      apb(1'h0, 12'h024, 32'h0);
      chk(rv, 32'h0);
      apb(1'h0, 12'h020, 32'h0);
      chk(rv, 32'h0);
      apb(1'h0, 12'h02c, 32'h0);
      chk(rv, 32'h0);
      apb(1'h0, 12'h028, 32'h0);
      chb(rv[7:4] == 4'h0, 1'h1);
   endtask : t_reset

   task automatic t_bus();
      apb(1'h0, 12'h03c, 32'h0);
      chb(serr, 1'h1);
      apb(1'h1, 12'h025, 32'h77);
      chb(serr, 1'h1);
      apb(1'h0, 12'h024, 32'h0);
      chk(rv, 32'h0);
      // Halt freezes the count, so a write attempt shows up plainly
      apb(1'h1, 12'h04c, 32'h4);
      apb(1'h0, 12'h028, 32'h0);
      a = rv;
      apb(1'h1, 12'h028, 32'h5a);
      repeat (20) @(posedge core_clk);
      apb(1'h0, 12'h028, 32'h0);
      chk(rv, a);
      for (logic [31:0] m = 32'h1; m < 32'h4; m++) begin
         apb(1'h1, 12'h04c, m);
         apb(1'h0, 12'h028, 32'h0);
         a = rv;
         repeat (10) @(posedge core_clk);
         apb(1'h0, 12'h028, 32'h0);
         chb(rv != a, 1'h1);
      end
      apb(1'h1, 12'h04c, 32'h0);
   endtask : t_bus

   task automatic t_tb2();
      apb(1'h1, 12'h024, 32'hf0);
      apb(1'h0, 12'h028, 32'h0);
      chb(rv[7:4] == 4'hf, 1'h0);
      poll(12'h020, 0);
      apb(1'h0, 12'h028, 32'h0);
      chb(rv[7:4] == 4'hf, 1'h1);
      apb(1'h0, 12'h020, 32'h0);
      chk(rv, 32'h0);
      apb(1'h1, 12'h020, 32'h3);
      apb(1'h0, 12'h020, 32'h0);
      chk(rv, 32'h2);
      apb(1'h1, 12'h024, 32'h10);
      apb(1'h0, 12'h028, 32'h0);
      chb(rv[7:4] == 4'hf, 1'h1);
      apb(1'h1, 12'h04c, 32'h2);
      wait_hi(1'h1);
      chb(wake_req, 1'h1);
      apb(1'h1, 12'h04c, 32'h3);
      repeat (2) @(posedge core_clk);
      chb(wake_req, 1'h0);
      apb(1'h1, 12'h04c, 32'h0);
      apb(1'h0, 12'h028, 32'h0);
      chb(rv[7:4] == 4'h1, 1'h1);
      apb(1'h0, 12'h020, 32'h0);
      chk(rv, 32'h3);
      apb(1'h0, 12'h020, 32'h0);
      chk(rv, 32'h2);
      chb(tb2_irq, 1'h0);
      apb(1'h1, 12'h020, 32'h0);
   endtask : t_tb2

   task automatic t_irq();
      apb(1'h1, 12'h044, 32'h2);
      repeat (2) @(posedge core_clk);
      chb(irq, 1'h1);
      apb(1'h1, 12'h048, 32'h2);
      repeat (2) @(posedge core_clk);
      chb(irq, 1'h0);
      apb(1'h0, 12'h048, 32'h0);
      chk(rv, 32'h0);
      wait_hi(1'h0);
      apb(1'h0, 12'h040, 32'h0);
      chb(rv[1], 1'h1);
      apb(1'h1, 12'h044, 32'h0);
      repeat (2) @(posedge core_clk);
      chb(irq, 1'h0);
   endtask : t_irq

   // Period from one fresh flag to the next; the first hit may be stale
   task automatic t_tb1(input logic s, input int e);
      int t;
      apb(1'h1, 12'h02c, {24'h0, 2'h1, s, 5'h18});
      poll(12'h02c, 3);
      poll(12'h02c, 3);
      t = cyc;
      poll(12'h02c, 3);
      chb((cyc - t) >= e - 6 && (cyc - t) <= e + 6, 1'h1);
      chb(rv[6], 1'h0);
      chb(rv[5], s);
      chb(rv[4], 1'h1);
      chb(tb1_irq, 1'h1);
   endtask : t_tb1

   task automatic t_cap();
      apb(1'h1, 12'h02c, 32'h80);
      poll(12'h02c, 3);
      capture_input_pin <= 1'h1;
      repeat (8) @(posedge core_clk);
      chb(cap_irq, 1'h1);
      repeat (40) @(posedge core_clk);
      capture_input_pin <= 1'h0;
      repeat (8) @(posedge core_clk);
      apb(1'h0, 12'h030, 32'h0);
      chb(rv[7:4] == 4'h0, 1'h1);
      apb(1'h0, 12'h02c, 32'h0);
      chb(rv[6], 1'h0);
      chb(cap_irq, 1'h0);
      for (int i = 0; i < 2; i++) begin
         capture_input_pin <= ~capture_input_pin;
         repeat (8) @(posedge core_clk);
         apb(1'h0, 12'h02c, 32'h0);
         chb(rv[6], 1'h1);
         apb(1'h0, 12'h030, 32'h0);
      end
   endtask : t_cap

   // Main sequence
   initial begin
      sys_rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      capture_input_pin = 1'h0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      t_reset();
      t_bus();
      t_tb2();
      t_irq();
      t_tb1(1'h0, 500);
      t_tb1(1'h1, 1000);
      t_cap();
      complete_run();
   end
endmodule : tb
